// ===== adc_readout_pkg.sv
// shared constants and types for the converter serial readout
package adc_readout_pkg;

  localparam int unsigned SYS_CLK_HZ       = 20_000_000;
  // conversion period, 19.79 Hz update rate
  localparam real         T_ADC_MS         = 50.54;
  localparam int unsigned ADC_PERIOD_CYC_DEF = int'(T_ADC_MS * 1.0e-3 * real'(SYS_CLK_HZ));
  // crystal period; the crystal itself clocks the link side
  localparam real         T_XTAL_US        = 30.5176;
  localparam int unsigned SETTLE_PERIODS   = 2;
  localparam logic [1:0]  SETTLE_DISCARD   = 2'h1;
  localparam logic [1:0]  SETTLE_DONE      = 2'h0;

  localparam int unsigned CODE_W           = 24;
  localparam logic [4:0]  BIT_FIRST        = 5'h00;
  localparam logic [4:0]  BIT_LAST         = 5'h18;
  localparam logic [4:0]  BIT_STEP         = 5'h01;

  localparam logic        DOUT_IDLE        = 1'b1;
  localparam logic        DOUT_READY       = 1'b0;
  localparam logic        SCLK_IDLE        = 1'b1;

  typedef struct packed {
    logic              toggle;
    logic [CODE_W-1:0] code;
  } result_xfer_type;

  typedef enum {
    LINK_IDLE,
    LINK_SHIFT
  } link_state_type;

endpackage : adc_readout_pkg

// ===== adc_serial_readout.sv
// conversion pacing and master-mode serial readout of the 24-bit result
`timescale 1ns/100ps
module adc_serial_readout
  import adc_readout_pkg::*;
#(
  parameter int unsigned ADC_PERIOD_CYC = ADC_PERIOD_CYC_DEF
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_crystal_clk,
  input  wire logic [CODE_W-1:0] i_conv_data,
  input  wire logic              i_input_change,
  input  wire logic              i_cs_n,
  output logic                   o_sclk,
  output logic                   o_dout,
  output logic                   o_dout_oe,
  output logic                   o_settled
);

  localparam int unsigned     PER_W      = $clog2(ADC_PERIOD_CYC) + 1;
  localparam logic [PER_W-1:0] PER_LAST  = PER_W'(ADC_PERIOD_CYC - 1);
  localparam logic [PER_W-1:0] PER_ONE   = PER_W'(1);
  localparam int unsigned     SPAN_W     = PER_W + 1;
  localparam logic [SPAN_W-1:0] SPAN_MIN = SPAN_W'(SETTLE_PERIODS * ADC_PERIOD_CYC - 1);
  localparam logic [SPAN_W-1:0] SPAN_ONE = SPAN_W'(1);

  // system clock side
  logic              change_s;
  logic              change_d_q;
  logic              change_rise;
  logic              ack_s;
  logic [PER_W-1:0]  period_q;
  logic              tick;
  logic [1:0]        settle_q;
  logic              publish;
  result_xfer_type   xfer_q;

  bit_sync #(.W(1), .RST_VAL(1'b0)) u_change_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_input_change),
    .o_sync  (change_s)
  );

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      change_d_q <= 1'b0;
    else
      change_d_q <= change_s;
  end

  assign change_rise = change_s & ~change_d_q;
  assign tick        = (period_q == PER_LAST);

  // a change restarts the period so the settling periods are full ones
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || change_rise)
      period_q <= '0;
    else if (tick)
      period_q <= '0;
    else
      period_q <= period_q + PER_ONE;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || change_rise)
      settle_q <= SETTLE_DISCARD;
    else if (tick && settle_q != SETTLE_DONE)
      settle_q <= settle_q - 2'h1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_settled <= 1'b0;
    else
      o_settled <= (settle_q == SETTLE_DONE);
  end

  // a result is dropped if the link has not yet taken the previous one
  assign publish = tick && !change_rise && (settle_q == SETTLE_DONE)
                   && (xfer_q.toggle == ack_s);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      xfer_q <= '0;
    else if (publish)
    begin
      xfer_q.code   <= i_conv_data;
      xfer_q.toggle <= ~xfer_q.toggle;
    end
  end

  // crystal (link) side
  logic              rst_x_n;
  logic              req_s;
  logic              req_d_q;
  logic              new_word;
  logic              cs_s;
  logic [CODE_W-1:0] word_q;
  logic              pend_q;
  logic              start;
  link_state_type    state_q;
  logic [4:0]        cnt_q;
  logic [CODE_W-1:0] shift_q;
  logic              dout_q;
  logic              en_q;

  bit_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .i_clk   (i_crystal_clk),
    .i_rst_n (1'b1),
    .i_async (i_rst_n),
    .o_sync  (rst_x_n)
  );

  bit_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .i_clk   (i_crystal_clk),
    .i_rst_n (rst_x_n),
    .i_async (xfer_q.toggle),
    .o_sync  (req_s)
  );

  bit_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
    .i_clk   (i_crystal_clk),
    .i_rst_n (rst_x_n),
    .i_async (i_cs_n),
    .o_sync  (cs_s)
  );

  bit_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_async (req_d_q),
    .o_sync  (ack_s)
  );

  always_ff @(posedge i_crystal_clk)
  begin
    if (!rst_x_n)
      req_d_q <= 1'b0;
    else
      req_d_q <= req_s;
  end

  assign new_word = req_s ^ req_d_q;
  assign start    = (state_q == LINK_IDLE) && pend_q && !cs_s;

  // code is held still by the sender until the toggle is acknowledged
  always_ff @(posedge i_crystal_clk)
  begin
    if (!rst_x_n)
      word_q <= '0;
    else if (new_word)
      word_q <= xfer_q.code;
  end

  // a new word arriving as a transfer starts is kept pending
  always_ff @(posedge i_crystal_clk)
  begin
    if (!rst_x_n)
      pend_q <= 1'b0;
    else if (new_word)
      pend_q <= 1'b1;
    else if (start)
      pend_q <= 1'b0;
  end

  always_ff @(posedge i_crystal_clk)
  begin
    if (!rst_x_n)
    begin
      state_q <= LINK_IDLE;
      cnt_q   <= BIT_FIRST;
      shift_q <= '0;
      dout_q  <= DOUT_IDLE;
    end
    else
    begin
      case (state_q)
        LINK_IDLE:
        begin
          if (start)
          begin
            state_q <= LINK_SHIFT;
            cnt_q   <= BIT_FIRST;
            shift_q <= word_q;
            dout_q  <= DOUT_READY;
          end
          else
            dout_q  <= DOUT_IDLE;
        end
        LINK_SHIFT:
        begin
          if (cs_s || cnt_q == BIT_LAST)
          begin
            state_q <= LINK_IDLE;
            dout_q  <= DOUT_IDLE;
          end
          else
          begin
            dout_q  <= shift_q[CODE_W-1];
            shift_q <= {shift_q[CODE_W-2:0], 1'b0};
            cnt_q   <= cnt_q + BIT_STEP;
          end
        end
        default:
        begin
          state_q <= LINK_IDLE;
          dout_q  <= DOUT_IDLE;
        end
      endcase
    end
  end
  // enable moves only while the crystal is low, so the gated clock never glitches
  always_ff @(negedge i_crystal_clk)
  begin
    if (!rst_x_n)
      en_q <= 1'b0;
    else
      en_q <= (state_q == LINK_SHIFT) && (cnt_q != BIT_LAST) && !cs_s;
  end
  // sclk falls with the crystal's rising edge, the same edge that moves dout
  assign o_sclk    = en_q ? ~i_crystal_clk : SCLK_IDLE;
  assign o_dout    = dout_q;
  assign o_dout_oe = ~cs_s;
  // checks
  logic [PER_W-1:0]  gap_q;
  logic [SPAN_W-1:0] since_q;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || tick || change_rise)
      gap_q <= '0;
    else
      gap_q <= gap_q + PER_ONE;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || change_rise)
      since_q <= '0;
    else if (since_q < SPAN_MIN)
      since_q <= since_q + SPAN_ONE;
  end
  a_conv_period: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    tick |-> gap_q == PER_LAST)
    else $error("conversion period length wrong");
  a_settle_wait: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    publish |-> since_q >= SPAN_MIN)
    else $error("result published before two full periods");
  a_launch_msb: assert property (
    @(posedge i_crystal_clk) disable iff (!rst_x_n)
    (state_q == LINK_SHIFT && cnt_q != BIT_LAST && !cs_s)
      |=> dout_q == $past(shift_q[CODE_W-1]))
    else $error("bit not launched on active edge");
  a_sclk_running: assert property (
    @(posedge i_crystal_clk) disable iff (!rst_x_n)
    (state_q == LINK_SHIFT && cnt_q != BIT_FIRST && cnt_q != BIT_LAST && !cs_s
      && $past(!cs_s)) |-> en_q)
    else $error("serial clock stopped mid word");
  sequence s_ready;
    start ##0 (pend_q && state_q == LINK_IDLE);
  endsequence
  // dout went low at the start edge; enable was set on the crystal low phase since
  sequence s_first_fall;
    en_q && dout_q == DOUT_READY;
  endsequence
  // a chip select raised on the start edge legitimately keeps the clock off
  a_ready_fall: assert property (
    @(posedge i_crystal_clk) disable iff (!rst_x_n)
    s_ready ##1 !cs_s |-> s_first_fall)
    else $error("first falling edge not one crystal period after ready");
  a_cs_release: assert property (
    @(posedge i_crystal_clk) disable iff (!rst_x_n)
    cs_s |-> !o_dout_oe ##1 state_q == LINK_IDLE)
    else $error("data line driven with chip select high");
  sequence s_last_bit;
    state_q == LINK_SHIFT && cnt_q == BIT_LAST;
  endsequence
  a_idle_high: assert property (
    @(posedge i_crystal_clk) disable iff (!rst_x_n)
    s_last_bit |-> !en_q ##1 (dout_q == DOUT_IDLE && state_q == LINK_IDLE))
    else $error("data line not high after transfer end");
  a_word_length: assert property (
    @(posedge i_crystal_clk) disable iff (!rst_x_n)
    start |-> ##1 cnt_q == BIT_FIRST ##24 (cnt_q == BIT_LAST || state_q == LINK_IDLE))
    else $error("word is not 24 bits");
endmodule : adc_serial_readout

// ===== bit_sync.sv
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/100ps
module bit_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : bit_sync

// ===== host_reader.sv
// host side model that reads converter results off the serial line
`timescale 1ns/100ps
module host_reader
  import adc_readout_pkg::*;
(
  input  wire logic         i_sclk,
  input  wire logic         i_dout,
  input  wire logic         i_dout_oe,
  output logic [CODE_W-1:0] o_word,
  output int                o_words,
  output realtime           o_lead,
  output realtime           o_low
);
  logic              last_q = 1'b1;
  logic              line;
  logic [CODE_W-1:0] shift_q;
  int                nbits = 0;
  realtime           t_ready;
  realtime           t_fall;

  initial o_words = 0;
  always @(i_dout or i_dout_oe) if (i_dout_oe) last_q = i_dout;
  // released line shows the inverse so a stale level never reads as data
  assign line = i_dout_oe ? i_dout : ~last_q;
  always @(negedge line) if (i_sclk && nbits == 0) t_ready = $realtime;
  always @(negedge i_sclk)
  begin
    if (nbits == 0) o_lead = $realtime - t_ready;
    t_fall = $realtime;
  end
  // sample half a bit after the launching falling edge
  always @(posedge i_sclk)
  begin
    if (i_dout_oe === 1'b1)
    begin
      o_low   = $realtime - t_fall;
      shift_q = {shift_q[CODE_W-2:0], line};
      nbits   = nbits + 1;
      if (nbits == CODE_W)
      begin
        o_word  = shift_q;
        o_words = o_words + 1;
        nbits   = 0;
      end
    end
  end
  // a transfer cut short leaves no partial word behind
  always @(negedge i_dout_oe) nbits = 0;
endmodule : host_reader

// ===== test_adc_serial_readout.sv
// self-checking bench for the converter serial readout
`timescale 1ns/100ps
module test_adc_serial_readout;
  import adc_readout_pkg::*;
  localparam int P = 200;
  logic              i_sys_clk      = 1'b0;
  logic              i_crystal_clk  = 1'b0;
  logic              i_rst_n        = 1'b0;
  logic              i_input_change = 1'b0;
  logic              i_cs_n         = 1'b1;
  logic [CODE_W-1:0] i_conv_data    = 24'ha5c3e1;
  logic              o_sclk;
  logic              o_dout;
  logic              o_dout_oe;
  logic              o_settled;
  logic [CODE_W-1:0] word;
  int                words;
  int                n;
  realtime           lead;
  realtime           low;
  int                failures    = 0;
  int                checks_done = 0;

  always #25 i_sys_clk = ~i_sys_clk;
  initial
  begin
    #7;
    forever #15 i_crystal_clk = ~i_crystal_clk;
  end

  adc_serial_readout #(.ADC_PERIOD_CYC(P)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_crystal_clk(i_crystal_clk),
    .i_conv_data(i_conv_data), .i_input_change(i_input_change), .i_cs_n(i_cs_n),
    .o_sclk(o_sclk), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_settled(o_settled));
  host_reader host_u (
    .i_sclk(o_sclk), .i_dout(o_dout), .i_dout_oe(o_dout_oe),
    .o_word(word), .o_words(words), .o_lead(lead), .o_low(low));

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_word(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_range(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("FAIL t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : cmp_range

  task automatic cyc(input int k);
    repeat (k) @(negedge i_sys_clk);
  endtask : cyc

  task automatic wait_word(input int lim);
    int w0;
    w0 = words;
    n  = 0;
    while (words == w0 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_word

  task automatic t_settle;
    i_cs_n = 1'b0;
    cyc(P - 20);
    cmp_bit(o_settled, 1'b0);
    cmp_range(words, 0, 0);
    cyc(40);
    cmp_bit(o_settled, 1'b1);
    wait_word(P + 100);
    cmp_word(word, 24'ha5c3e1);
    cmp_range(n, P - 30, P + 40);
    cmp_range(int'(lead), 15, 45);
    cmp_range(int'(low), 15, 15);
    cyc(2);
    cmp_bit(o_dout, DOUT_IDLE);
    cmp_bit(o_sclk, SCLK_IDLE);
  endtask : t_settle

  task automatic t_period;
    i_conv_data = 24'h5a3c1e;
    wait_word(P + 20);
    cmp_range(n, P - 5, P + 1);
    cmp_word(word, 24'h5a3c1e);
  endtask : t_period

  task automatic t_cs;
    int w0;
    w0          = words;
    i_cs_n      = 1'b1;
    i_conv_data = 24'h0f00f0;
    cyc(4);
    cmp_bit(o_dout_oe, 1'b0);
    wait_word(P + 20);
    cmp_range(words, w0, w0);
    i_cs_n = 1'b0;
    cyc(4);
    cmp_bit(o_dout_oe, 1'b1);
    wait_word(60);
    cmp_word(word, 24'h0f00f0);
  endtask : t_cs

  task automatic t_change;
    i_conv_data    = 24'h800001;
    i_input_change = 1'b1;
    cyc(4);
    i_input_change = 1'b0;
    cmp_bit(o_settled, 1'b0);
    wait_word(3 * P);
    cmp_range(n, 2 * P - 12, 2 * P + 30);
    cmp_word(word, 24'h800001);
  endtask : t_change

  task automatic complete_run;
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial
  begin
    cyc(12);
    i_rst_n = 1'b1;
    t_settle;
    t_period;
    t_cs;
    t_change;
    complete_run;
  end

  // whole run needs about 1300 system cycles
  initial
  begin
    #150000;
    failures++;
    complete_run;
  end
endmodule : test_adc_serial_readout
